// *** hdl/fnd_control.sv ***
`timescale 1ns/100ps
`default_nettype none
module fnd_control (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic                           ref_in,
  input  wire logic                           vco_in,
  input  wire logic [fnd_pkg::FND_RD_W-1:0]   ref_divider,
  input  wire logic [fnd_pkg::FND_ND_W-1:0]   integer_feedback_divider,
  input  wire logic [fnd_pkg::FND_NUM_W-1:0]  frac_numerator,
  input  wire logic [fnd_pkg::FND_OD_W-1:0]   out_divider,
  input  wire logic [fnd_pkg::FND_SEED_W-1:0] mod_seed,
  input  wire logic                           integer_mode_select,
  input  wire logic                           auto_modulator_reset_enable,
  input  wire logic                           setting_write,
  input  wire logic                           force_modulator_reset,
  output var  logic                           phase_detector_ref,
  output var  logic                           phase_detector_fb,
  output var  logic                           synth_output,
  output var  logic [fnd_pkg::FND_ND_W-1:0]   feedback_ratio,
  output var  logic                           force_reset_pending,
  output var  logic                           modulator_standby
);
  import fnd_pkg::*;

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]           ref_sync;
    logic [2:0]           vco_sync;
    logic                 ref_lvl;
    logic                 vco_lvl;
    logic [FND_NUM_W-1:0] acc;
    logic [FND_ND_W-1:0]  ratio;
    logic                 rst_pend;
    logic                 standby;
    logic                 ref_pulse;
    logic                 fb_pulse;
    logic                 synth;
  } fnd_ctl_s;

  fnd_ctl_s st;
  fnd_ctl_s next_st;

  logic ref_rise;
  logic vco_rise;
  logic pd_tick;
  logic fb_tick;
  logic out_tick;

  function automatic logic [FND_NUM_W-1:0] seed_state(
    input logic [FND_SEED_W-1:0] s);
    seed_state = {10'h000, s};
  endfunction

  // -------------------------------------------------------------------------
  // dividers
  // -------------------------------------------------------------------------
  fnd_divider u_ref_div (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (ref_rise),
    .ratio ({5'h00, ref_divider}),
    .pulse (pd_tick)
  );

  fnd_divider u_fb_div (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (vco_rise),
    .ratio (st.ratio),
    .pulse (fb_tick)
  );

  fnd_divider u_out_div (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (vco_rise),
    .ratio ({7'h00, out_divider}),
    .pulse (out_tick)
  );

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  logic [FND_NUM_W:0] sum;
  logic               mod_reset;

  always_comb begin
    next_st          = st;
    next_st.ref_sync = {st.ref_sync[1:0], ref_in};
    next_st.vco_sync = {st.vco_sync[1:0], vco_in};
    if (st.ref_sync[1] == st.ref_sync[2]) begin
      next_st.ref_lvl = st.ref_sync[2];
    end
    if (st.vco_sync[1] == st.vco_sync[2]) begin
      next_st.vco_lvl = st.vco_sync[2];
    end
    next_st.ref_pulse = pd_tick;
    next_st.fb_pulse  = fb_tick;
    if (out_tick) begin
      next_st.synth = ~st.synth;
    end
    next_st.standby = integer_mode_select;
    mod_reset = st.rst_pend
              | (auto_modulator_reset_enable & setting_write);
    // set wins: a new request in the clearing cycle stays pending
    next_st.rst_pend = force_modulator_reset;
    sum = {1'b0, st.acc} + {1'b0, frac_numerator};
    if (mod_reset) begin
      next_st.acc   = seed_state(mod_seed);
      next_st.ratio = integer_feedback_divider;
    end else if (integer_mode_select) begin
      next_st.ratio = integer_feedback_divider;
    end else if (pd_tick) begin
      // first-order overflow gives carry into n at most once per detector cycle
      next_st.acc   = sum[FND_NUM_W-1:0];
      next_st.ratio = integer_feedback_divider
                    + {9'h000, sum[FND_NUM_W]};
    end
  end

  assign ref_rise = next_st.ref_lvl & ~st.ref_lvl;
  assign vco_rise = next_st.vco_lvl & ~st.vco_lvl;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st          <= '0;
      st.acc      <= {10'h000, FND_SEED_RST};
      st.ratio    <= FND_ND_RST;
      st.standby  <= FND_INT_RST;
    end else begin
      st <= next_st;
    end
  end

  assign phase_detector_ref  = st.ref_pulse;
  assign phase_detector_fb   = st.fb_pulse;
  assign synth_output        = st.synth;
  assign feedback_ratio      = st.ratio;
  assign force_reset_pending = st.rst_pend;
  assign modulator_standby   = st.standby;

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  sequence force_req_s;
    force_modulator_reset;
  endsequence

  sequence lone_force_s;
    force_req_s ##1 !force_modulator_reset;
  endsequence

  sequence seeded_s;
    st.acc == seed_state($past(mod_seed));
  endsequence

  sequence frac_step_s;
    pd_tick && !integer_mode_select && !mod_reset;
  endsequence

  force_seed_a: assert property (@(posedge clk) disable iff (!rst_n)
    force_req_s |-> ##1 st.rst_pend ##1 seeded_s)
    else $error("forced reset did not seed accumulator");

  pend_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    lone_force_s |=> !st.rst_pend)
    else $error("force reset flag did not clear itself");

  auto_seed_a: assert property (@(posedge clk) disable iff (!rst_n)
    auto_modulator_reset_enable && setting_write |=> seeded_s)
    else $error("auto reset did not seed accumulator");

  // any modulator reset also restarts the ratio at the integer value
  reset_ratio_a: assert property (@(posedge clk) disable iff (!rst_n)
    mod_reset |=> st.ratio == $past(integer_feedback_divider))
    else $error("modulator reset left ratio off integer value");

  // two cycles so the registered ratio has caught up
  int_ratio_a: assert property (@(posedge clk) disable iff (!rst_n)
    integer_mode_select [*2] |-> st.ratio == $past(integer_feedback_divider))
    else $error("integer mode ratio not integer value");

  standby_a: assert property (@(posedge clk) disable iff (!rst_n)
    integer_mode_select && !mod_reset |=> st.acc == $past(st.acc))
    else $error("modulator stepped in standby");

  standby_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    integer_mode_select |=> st.standby)
    else $error("standby flag not raised in integer mode");

  frac_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    frac_step_s |=> st.ratio - $past(integer_feedback_divider) <= 10'h001)
    else $error("fractional ratio strayed from n or n+1");

  carry_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    frac_step_s ##0 sum[FND_NUM_W]
    |=> st.ratio == $past(integer_feedback_divider) + 10'h001)
    else $error("accumulator carry did not add one to ratio");

  acc_sum_a: assert property (@(posedge clk) disable iff (!rst_n)
    frac_step_s |=> st.acc == $past(st.acc) + $past(frac_numerator))
    else $error("accumulator did not add numerator");

  synth_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
    out_tick |=> st.synth != $past(st.synth))
    else $error("output divider pulse did not toggle output");
endmodule // fnd_control
`default_nettype wire

// *** hdl/fnd_divider.sv ***
`timescale 1ns/100ps
`default_nettype none
// -------------------------------------------------------------------------
// programmable divide-by-n counter, one pulse every n input edges
// -------------------------------------------------------------------------
module fnd_divider (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              tick,
  input  wire fnd_pkg::fnd_cnt_t ratio,
  output var  logic              pulse
);
  import fnd_pkg::*;

  typedef struct packed {
    fnd_cnt_t cnt;
    logic     pulse;
  } fnd_div_s;

  fnd_div_s st;
  fnd_div_s next_st;

  always_comb begin
    next_st       = st;
    next_st.pulse = 1'b0;
    if (tick) begin
      // ratio of 0 or 1 passes every tick
      if (st.cnt + 10'h001 >= ratio) begin
        next_st.cnt   = '0;
        next_st.pulse = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 10'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pulse = st.pulse;
endmodule // fnd_divider
`default_nettype wire

// *** hdl/fnd_pkg.sv ***
package fnd_pkg;
  // -------------------------------------------------------------------------
  // field widths
  // -------------------------------------------------------------------------
  localparam int unsigned FND_ND_W   = 10;
  localparam int unsigned FND_NUM_W  = 18;
  localparam int unsigned FND_RD_W   = 5;
  localparam int unsigned FND_OD_W   = 3;
  localparam int unsigned FND_SEED_W = 8;
  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [FND_ND_W-1:0]   FND_ND_RST   = 10'h0fa;
  localparam logic [FND_NUM_W-1:0]  FND_NUM_RST  = 18'h03fff;
  localparam logic [FND_RD_W-1:0]   FND_RD_RST   = 5'h01;
  localparam logic [FND_OD_W-1:0]   FND_OD_RST   = 3'h1;
  localparam logic [FND_SEED_W-1:0] FND_SEED_RST = 8'h11;
  localparam logic                  FND_INT_RST  = 1'b0;
  localparam logic                  FND_AUTO_RST = 1'b1;
  // -------------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------------
  typedef logic [FND_ND_W-1:0] fnd_cnt_t;
endpackage

// *** verification/fnd_osc_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module fnd_osc_model (
  input  wire logic clk,
  input  wire logic run,
  output var  logic ref_in,
  output var  logic vco_in
);
  logic [1:0] ref_cnt = 2'h0;
  logic [1:0] vco_cnt = 2'h0;
  initial ref_in = 1'b0;
  initial vco_in = 1'b0;
  // sources stand still while halted; ref runs at clk/8, vco at clk/6
  always @(negedge clk) begin
    if (run) begin
      ref_cnt <= ref_cnt + 2'h1;
      vco_cnt <= (vco_cnt == 2'h2) ? 2'h0 : vco_cnt + 2'h1;
      if (ref_cnt == 2'h3) ref_in <= ~ref_in;
      if (vco_cnt == 2'h2) vco_in <= ~vco_in;
    end
  end
endmodule // fnd_osc_model
`default_nettype wire

// *** verification/fractional_n_divider_control_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module fractional_n_divider_control_tb_top;
  import fnd_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, run = 1'b0;
  logic ref_in, vco_in, pd_ref, pd_fb, syn, pend, stby;
  logic [4:0] r_div = 5'h01;
  logic [9:0] n_div = 10'h028;
  logic [17:0] num = 18'h00001;
  logic [2:0] o_div = 3'h1;
  logic [7:0] seed = 8'h11;
  logic intm = 1'b0, auto = 1'b1, wr = 1'b0, frc = 1'b0;
  logic [9:0] ratio;
  int failures = 0, n_checks = 0, cyc = 0;
  initial forever #25 clk = ~clk;
  fnd_osc_model osc (.clk(clk), .run(run), .ref_in(ref_in), .vco_in(vco_in));
  fnd_control dut (.clk(clk), .rst_n(rst_n), .ref_in(ref_in),
    .vco_in(vco_in), .ref_divider(r_div), .integer_feedback_divider(n_div),
    .frac_numerator(num), .out_divider(o_div), .mod_seed(seed),
    .integer_mode_select(intm), .auto_modulator_reset_enable(auto),
    .setting_write(wr), .force_modulator_reset(frc),
    .phase_detector_ref(pd_ref), .phase_detector_fb(pd_fb),
    .synth_output(syn), .feedback_ratio(ratio),
    .force_reset_pending(pend), .modulator_standby(stby));
  task automatic check(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // --------------------------------------------------------------
  // modulator: reset, then count carries over eight detector cycles
  // --------------------------------------------------------------
  task automatic frac(input logic [17:0] v, input logic im, f);
    int carries, seen, t;
    longint e;
    carries = 0; seen = 0; t = 0;
    e = im ? 0 : (longint'(seed) + 8 * longint'(v)) >> 18;
    run = 1'b0; intm = im; num = v;
    repeat (10) @(negedge clk);
    if (f) frc = 1'b1;
    else wr = 1'b1;
    @(negedge clk);
    frc = 1'b0; wr = 1'b0;
    check("pending", 32'(pend), 32'(f));
    @(negedge clk);
    check("pending clear", 32'(pend), 0);
    check("standby", 32'(stby), 32'(im));
    run = 1'b1;
    while (seen < 8 && t < 400) begin
      @(negedge clk);
      t++;
      if (pd_ref === 1'b1) begin
        seen++;
        if (ratio === n_div + 10'h001) carries++;
        else check("ratio", 32'(ratio), 32'(n_div));
      end
    end
    check("pd pulses", seen, 8);
    check("carries", carries, 32'(e));
  endtask
  // --------------------------------------------------------------
  // rates: detector pulses and output toggles over a fixed window
  // --------------------------------------------------------------
  task automatic measure(output int nr, ns);
    logic last;
    nr = 0; ns = 0; last = syn;
    repeat (480) begin
      @(negedge clk);
      if (pd_ref === 1'b1) nr++;
      if (syn !== last) ns++;
      last = syn;
    end
  endtask
  task automatic rates();
    int r1, s1, r2, s2;
    r_div = 5'h01; o_div = 3'h1; run = 1'b1;
    repeat (20) @(negedge clk);
    measure(r1, s1);
    r_div = 5'h02; o_div = 3'h2;
    repeat (20) @(negedge clk);
    measure(r2, s2);
    check("pd rate", 32'(r2 * 2 >= r1 - 2 && r2 * 2 <= r1 + 2), 1);
    check("out rate", 32'(s2 * 2 >= s1 - 2 && s2 * 2 <= s1 + 2), 1);
    // ref period 8 clocks, vco period 6 clocks: 480 cycles hold whole periods
    check("pd count", r1, 60);
    check("pd count div", r2, 30);
    check("out count", s1, 80);
    check("out count div", s2, 40);
    r_div = 5'h01; o_div = 3'h1;
  endtask
  // --------------------------------------------------------------
  // auto reset off: a setting write leaves the modulator alone
  // --------------------------------------------------------------
  task automatic auto_off();
    run = 1'b0;
    auto = 1'b0;
    repeat (10) @(negedge clk);
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
    check("ratio kept", 32'(ratio), 32'(n_div + 10'h001));
    auto = 1'b1;
  endtask
  // --------------------------------------------------------------
  // feedback: integer mode pulses are n vco periods apart
  // --------------------------------------------------------------
  task automatic fb_gap();
    int t, gap;
    t = 0;
    gap = 0;
    while (pd_fb !== 1'b1 && t < 600) begin
      @(negedge clk);
      t++;
    end
    do begin
      @(negedge clk);
      gap++;
    end while (pd_fb !== 1'b1 && gap < 600);
    check("fb gap", gap, 32'(n_div) * 6);
  endtask
  always @(posedge clk) begin
    if (rst_n) cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    check("ratio rst", 32'(ratio), 32'(FND_ND_RST));
    check("standby rst", 32'(stby), 0);
    frac(18'h00001, 1'b0, 1'b1);
    frac(18'h20000, 1'b0, 1'b0);
    frac(18'h3ffff, 1'b0, 1'b1);
    auto_off();
    frac(18'h3ffff, 1'b1, 1'b0);
    fb_gap();
    rates();
    end_sim();
  end
endmodule // fractional_n_divider_control_tb_top
`default_nettype wire
